// [logic/bldc_pkg.sv]
// shared constants and types for the sensorless commutation block
// assumes a single 100 MHz clock; no software-visible registers
package bldc_pkg;

  // clock and timer-0 resolution
  localparam int CLK_MHZ  = 100;                        // system clock rate
  localparam int TICK_NS  = 1000;                       // timer-0 tick period
  localparam int TICK_CYC = TICK_NS * CLK_MHZ / 1000;   // cycles per tick
  localparam int TICK_W   = 7;                          // prescaler width

  // pwm carrier
  localparam int PWM_KHZ  = 20;                         // carrier frequency
  localparam int PWM_CYC  = CLK_MHZ * 1000 / PWM_KHZ;   // cycles per period

  // start-up step time, counted in timer-0 ticks
  localparam int START_US    = 4000;                    // first step length
  localparam int START_TICKS = START_US * 1000 / TICK_NS;

  // default widths
  localparam int TMR_W_DEF  = 16;                       // timer-0 width
  localparam int DUTY_W_DEF = 13;                       // duty width
  localparam int SMP_W_DEF  = 12;                       // converter width

  // step table: two bits per step, step 0 in the low bits
  // hi phase: A A B B C C ; lo phase: B C C A A B
  localparam logic [11:0] HI_TAB    = 12'ha50;          // driven-high phase
  localparam logic [11:0] LO_TAB    = 12'h429;          // driven-low phase
  localparam logic [2:0]  STEP_LAST = 3'h5;             // six steps
  localparam logic [2:0]  STEP_RST  = 3'h0;             // step after reset
  localparam logic        PIN_RST   = 1'b1;             // synced pin reset

  typedef enum logic [2:0]
  {
    ST_IDLE = 3'b001,                                   // outputs off
    ST_RUN  = 3'b010,                                   // commutating
    ST_TRIP = 3'b100                                    // latched shutdown
  } run_state_e;

endpackage

// [logic/pin_sync.sv]
// three-flop synchroniser with agreement filter for one pin input
// assumes the pin is asynchronous to ref_clk_i
`timescale 1ns/10ps
module pin_sync #(
  parameter logic RST_VAL = 1'b0                        // constant reset level
)(
  input  wire logic ref_clk_i,                          // system clock
  input  wire logic rst_b_i,                            // async reset, low
  input  wire logic pin_i,                              // raw pin level
  output logic      q_o                                 // filtered level
);

  logic s1_reg;                                         // metastable stage
  logic s2_reg;                                         // second stage
  logic s3_reg;                                         // third stage
  logic q_reg;                                          // accepted level
  logic q_next;                                         // next accepted

  // a change counts only once stages two and three agree
  always_comb
  begin
    q_next = (s2_reg == s3_reg) ? s3_reg : q_reg;
  end

  // s1 feeds s2 only, so nothing decodes a metastable value
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
      q_reg  <= RST_VAL;
    end
    else
    begin
      s1_reg <= pin_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q_reg  <= q_next;
    end
  end

  assign q_o = q_reg;

endmodule

// [logic/dead_time_pair.sv]
// one complementary gate pair with programmable dead time
// assumes en_i and dem_i come from logic on the same clock
`timescale 1ns/10ps
module dead_time_pair (
  input  wire logic       ref_clk_i,                    // system clock
  input  wire logic       rst_b_i,                      // async reset, low
  input  wire logic       en_i,                         // pair may conduct
  input  wire logic       dem_i,                        // 1 high side, 0 low
  input  wire logic [7:0] dead_i,                       // dead time, cycles
  output logic            hi_o,                         // high-side gate
  output logic            lo_o                          // low-side gate
);

  logic       hi_reg;                                   // high gate state
  logic       lo_reg;                                   // low gate state
  logic       hi_next;                                  // next high gate
  logic       lo_next;                                  // next low gate
  logic [7:0] cnt_reg;                                  // gap countdown
  logic [7:0] cnt_next;                                 // next countdown

  // a side turns on only after the other has been off dead_i cycles
  always_comb
  begin
    hi_next  = hi_reg;
    lo_next  = lo_reg;
    cnt_next = cnt_reg;
    if (!en_i)
    begin
      // both off; the gap restarts so re-enable is also guarded
      hi_next  = 1'b0;
      lo_next  = 1'b0;
      cnt_next = dead_i;
    end
    else if (dem_i)
    begin
      if (lo_reg)
      begin
        lo_next  = 1'b0;
        cnt_next = dead_i;
      end
      else if (cnt_reg != 8'h00)
        cnt_next = cnt_reg - 8'h01;
      else
        hi_next = 1'b1;
    end
    else
    begin
      if (hi_reg)
      begin
        hi_next  = 1'b0;
        cnt_next = dead_i;
      end
      else if (cnt_reg != 8'h00)
        cnt_next = cnt_reg - 8'h01;
      else
        lo_next = 1'b1;
    end
  end

  // registers only
  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      hi_reg  <= 1'b0;
      lo_reg  <= 1'b0;
      cnt_reg <= 8'h00;
    end
    else
    begin
      hi_reg  <= hi_next;
      lo_reg  <= lo_next;
      cnt_reg <= cnt_next;
    end
  end

  assign hi_o = hi_reg;
  assign lo_o = lo_reg;

endmodule

// [logic/sensorless_commutation.sv]
// sensorless six-step commutation with time stamp, pwm, and trip logic
// assumes converter samples arrive as one-cycle valid strobes on ref_clk_i
// and that the converter is steered to the phase shown on float_ph_o
`timescale 1ns/10ps

module sensorless_commutation
  import bldc_pkg::*;
#(
  parameter int TMR_W       = TMR_W_DEF,                // timer-0 width
  parameter int DUTY_W      = DUTY_W_DEF,               // duty width
  parameter int SMP_W       = SMP_W_DEF,                // sample width
  parameter int PWM_PERIOD  = PWM_CYC,                  // carrier cycles
  parameter int START_STEP  = START_TICKS               // first step, ticks
)(
  input  wire logic              ref_clk_i,             // 100 MHz clock
  input  wire logic              rst_b_i,               // async reset, low
  input  wire logic              run_i,                 // motor enable
  input  wire logic              dir_i,                 // 1 reverses order
  input  wire logic              torque_mode_i,         // current loop on
  input  wire logic              six_indep_i,           // independent outs
  input  wire logic [5:0]        indep_mask_i,          // lo[5:3], hi[2:0]
  input  wire logic [DUTY_W-1:0] duty_i,                // speed-mode duty
  input  wire logic [7:0]        dead_i,                // dead time, cycles
  input  wire logic              fault_trip_b_i,        // trip pin, low
  input  wire logic              oc_cmp_i,              // overcurrent pin
  input  wire logic              rearm_i,               // re-enable pulse
  input  wire logic              bemf_valid_i,          // bemf sample strobe
  input  wire logic [SMP_W-1:0]  bemf_i,                // floating phase
  input  wire logic [SMP_W-1:0]  bemf_mid_i,            // neutral level
  input  wire logic              cur_valid_i,           // sense strobe
  input  wire logic [SMP_W-1:0]  cur_i,                 // sense voltage
  input  wire logic [SMP_W-1:0]  cur_ref_i,             // torque target
  input  wire logic              evt_ack_i,             // event taken
  output logic [2:0]             gate_hi_o,             // high gates A..C
  output logic [2:0]             gate_lo_o,             // low gates A..C
  output logic [1:0]             float_ph_o,            // undriven phase
  output logic [2:0]             step_o,                // commutation step
  output logic [TMR_W-1:0]       stamp_o,               // crossing stamp
  output logic                   stamp_new_o,           // stamp pulse
  output logic [TMR_W-1:0]       period_o,              // step period
  output logic                   evt_o,                 // event pending
  output logic                   evt_zc_o,              // 1 crossing, 0 cur
  output logic                   tripped_o              // latched trip
);

  if (PWM_PERIOD < 2 || PWM_PERIOD >= 2**DUTY_W)
    $error("PWM_PERIOD does not fit DUTY_W");
  if (START_STEP < 1 || START_STEP >= 2**(TMR_W-1))
    $error("START_STEP does not fit TMR_W");

  localparam logic [DUTY_W-1:0] DUTY_MAX = DUTY_W'(PWM_PERIOD);
  localparam logic [DUTY_W-1:0] CNT_TOP  = DUTY_W'(PWM_PERIOD - 1);

  logic fault_b_s;                                      // synced trip pin
  logic oc_s;                                           // synced comparator
  logic trip_now;                                       // any trip level

  pin_sync #(.RST_VAL(PIN_RST)) u_fault_sync (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .pin_i     (fault_trip_b_i),
    .q_o       (fault_b_s)
  );

  pin_sync #(.RST_VAL(~PIN_RST)) u_oc_sync (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .pin_i     (oc_cmp_i),
    .q_o       (oc_s)
  );

  assign trip_now = !fault_b_s || oc_s;

  // timer 0: prescaled free-running count, the time base for stamps and step timing
  logic [TICK_W-1:0] tick_cnt_reg;                      // prescaler
  logic [TICK_W-1:0] tick_cnt_next;
  logic [TMR_W-1:0]  timer_reg;                         // timer 0
  logic [TMR_W-1:0]  timer_next;
  logic              tick;                              // one-cycle enable

  assign tick = tick_cnt_reg == TICK_W'(TICK_CYC - 1);

  always_comb
  begin
    tick_cnt_next = tick ? '0 : tick_cnt_reg + 1'b1;
    timer_next    = tick ? timer_reg + 1'b1 : timer_reg;
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      tick_cnt_reg <= '0;
      timer_reg    <= '0;
    end
    else
    begin
      tick_cnt_reg <= tick_cnt_next;
      timer_reg    <= timer_next;
    end
  end

  // commutation control: state, step, crossing capture and timing
  run_state_e       state_reg, state_next;              // run state
  logic [2:0]       step_reg, step_next;                // current step
  logic [1:0]       float_reg, float_next;              // undriven phase
  logic [TMR_W-1:0] stamp_reg, stamp_next;              // last stamp
  logic             new_reg, new_next;                  // stamp pulse
  logic [TMR_W-1:0] period_reg, period_next;            // step period
  logic [TMR_W-1:0] due_reg, due_next;                  // next commutation
  logic             seen_reg, seen_next;                // a sample in step
  logic             sign_reg, sign_next;                // last sample sign
  logic             done_reg, done_next;                // crossing taken
  logic             have_reg, have_next;                // a crossing seen
  logic [DUTY_W-1:0] duty_reg, duty_next;               // working duty
  logic             zc_sign;                            // sample above mid
  logic             zc_hit;                             // crossing now
  logic             comm_hit;                           // commutate now
  logic [2:0]       step_adv;                           // following step
  logic [TMR_W-1:0] gap;                                // stamp difference

  assign zc_sign  = bemf_i >= bemf_mid_i;
  assign zc_hit   = state_reg == ST_RUN && bemf_valid_i && seen_reg
                    && zc_sign != sign_reg && !done_reg;
  assign comm_hit = state_reg == ST_RUN && tick && timer_reg == due_reg;
  assign gap      = timer_reg - stamp_reg;

  always_comb
  begin
    if (dir_i)
      step_adv = (step_reg == 3'h0) ? STEP_LAST : step_reg - 3'h1;
    else
      step_adv = (step_reg == STEP_LAST) ? 3'h0 : step_reg + 3'h1;
  end

  always_comb
  begin
    state_next  = state_reg;
    step_next   = step_reg;
    stamp_next  = stamp_reg;
    new_next    = 1'b0;
    period_next = period_reg;
    due_next    = due_reg;
    seen_next   = seen_reg;
    sign_next   = sign_reg;
    done_next   = done_reg;
    have_next   = have_reg;
    duty_next   = torque_mode_i ? duty_reg : duty_i;
    case (state_reg)
      ST_IDLE:
      begin
        // no alignment: hold the step for START_STEP ticks and start watching crossings
        if (run_i && !trip_now)
        begin
          state_next  = ST_RUN;
          period_next = TMR_W'(START_STEP);
          due_next    = timer_reg + TMR_W'(START_STEP);
          seen_next   = 1'b0;
          done_next   = 1'b0;
          have_next   = 1'b0;
        end
      end
      ST_RUN:
      begin
        if (!run_i)
          state_next = ST_IDLE;
        if (bemf_valid_i)
        begin
          seen_next = 1'b1;
          sign_next = zc_sign;
        end
        if (zc_hit)
        begin
          stamp_next = timer_reg;
          new_next   = 1'b1;
          done_next  = 1'b1;
          have_next  = 1'b1;
        end
        if (comm_hit)
        begin
          // due reached, from a crossing or the held period: step, and preset the next due one held period on
          step_next = step_adv;
          due_next  = due_reg + period_reg;
          seen_next = 1'b0;
          done_next = 1'b0;
        end
        else if (zc_hit)
        begin
          // crossing is mid-step, so commutate half a period later
          if (have_reg)
            period_next = gap;
          due_next = timer_reg + ((have_reg ? gap : period_reg) >> 1);
        end
        if (torque_mode_i && cur_valid_i)
        begin
          if (cur_i < cur_ref_i && duty_reg < DUTY_MAX)
            duty_next = duty_reg + 1'b1;
          else if (cur_i > cur_ref_i && duty_reg != '0)
            duty_next = duty_reg - 1'b1;
        end
      end
      ST_TRIP:
      begin
        // leave only when both trip sources are quiet and rearmed
        if (rearm_i && !trip_now)
          state_next = ST_IDLE;
      end
      default:
        state_next = ST_TRIP;
    endcase
    if (trip_now)
      state_next = ST_TRIP;
    float_next = 2'h3 - HI_TAB[{step_next, 1'b0} +: 2]
                      - LO_TAB[{step_next, 1'b0} +: 2];
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_reg  <= ST_IDLE;
      step_reg   <= STEP_RST;
      float_reg  <= 2'h2;
      stamp_reg  <= '0;
      new_reg    <= 1'b0;
      period_reg <= '0;
      due_reg    <= '0;
      seen_reg   <= 1'b0;
      sign_reg   <= 1'b0;
      done_reg   <= 1'b0;
      have_reg   <= 1'b0;
      duty_reg   <= '0;
    end
    else
    begin
      state_reg  <= state_next;
      step_reg   <= step_next;
      float_reg  <= float_next;
      stamp_reg  <= stamp_next;
      new_reg    <= new_next;
      period_reg <= period_next;
      due_reg    <= due_next;
      seen_reg   <= seen_next;
      sign_reg   <= sign_next;
      done_reg   <= done_next;
      have_reg   <= have_next;
      duty_reg   <= duty_next;
    end
  end

  // event arbitration: a new event wins over the ack of the old one
  logic zc_pend_reg, zc_pend_next;                      // crossing pending
  logic cur_pend_reg, cur_pend_next;                    // sense pending
  logic evt_reg, evt_next;                              // any pending
  logic evt_zc_reg, evt_zc_next;                        // crossing shown

  always_comb
  begin
    zc_pend_next  = zc_hit || (zc_pend_reg && !(evt_ack_i && evt_zc_reg));
    cur_pend_next = (cur_valid_i && state_reg == ST_RUN)
                    || (cur_pend_reg && !(evt_ack_i && evt_reg
                    && !evt_zc_reg));
    evt_next      = zc_pend_next || cur_pend_next;
    evt_zc_next   = zc_pend_next;
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      zc_pend_reg  <= 1'b0;
      cur_pend_reg <= 1'b0;
      evt_reg      <= 1'b0;
      evt_zc_reg   <= 1'b0;
    end
    else
    begin
      zc_pend_reg  <= zc_pend_next;
      cur_pend_reg <= cur_pend_next;
      evt_reg      <= evt_next;
      evt_zc_reg   <= evt_zc_next;
    end
  end

  // pwm carrier and gate stage
  logic [DUTY_W-1:0] pwm_cnt_reg, pwm_cnt_next;         // carrier count
  logic              pwm_on;                            // pulse active
  logic [2:0]        dt_en;                             // pair enables
  logic [2:0]        dt_dem;                            // pair demands
  logic [2:0]        dt_hi;                             // dead-timed high
  logic [2:0]        dt_lo;                             // dead-timed low
  logic [2:0]        hi_next;                           // next high gates
  logic [2:0]        lo_next;                           // next low gates
  logic [2:0]        hi_reg;                            // high gate flops
  logic [2:0]        lo_reg;                            // low gate flops
  logic              block;                             // force all off

  assign pwm_on = pwm_cnt_reg < duty_reg;
  assign block  = trip_now || state_reg != ST_RUN;

  for (genvar p = 0; p < 3; p++)
  begin : g_pair
    assign dt_en[p]  = !block && float_reg != 2'(p);
    assign dt_dem[p] = pwm_on && HI_TAB[{step_reg, 1'b0} +: 2] == 2'(p);
    dead_time_pair u_pair (
      .ref_clk_i (ref_clk_i),
      .rst_b_i   (rst_b_i),
      .en_i      (dt_en[p]),
      .dem_i     (dt_dem[p]),
      .dead_i    (dead_i),
      .hi_o      (dt_hi[p]),
      .lo_o      (dt_lo[p])
    );
  end

  // trip gating sits after the dead-time flops so gates drop on the first clock after trip_now
  always_comb
  begin
    pwm_cnt_next = (pwm_cnt_reg == CNT_TOP) ? '0 : pwm_cnt_reg + 1'b1;
    if (block)
    begin
      hi_next = 3'h0;
      lo_next = 3'h0;
    end
    else if (six_indep_i)
    begin
      hi_next = indep_mask_i[2:0] & {3{pwm_on}};
      lo_next = indep_mask_i[5:3] & {3{pwm_on}};
    end
    else
    begin
      hi_next = dt_hi;
      lo_next = dt_lo;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      pwm_cnt_reg <= '0;
      hi_reg      <= 3'h0;
      lo_reg      <= 3'h0;
    end
    else
    begin
      pwm_cnt_reg <= pwm_cnt_next;
      hi_reg      <= hi_next;
      lo_reg      <= lo_next;
    end
  end

  assign gate_hi_o   = hi_reg;
  assign gate_lo_o   = lo_reg;
  assign float_ph_o  = float_reg;
  assign step_o      = step_reg;
  assign stamp_o     = stamp_reg;
  assign stamp_new_o = new_reg;
  assign period_o    = period_reg;
  assign evt_o       = evt_reg;
  assign evt_zc_o    = evt_zc_reg;
  assign tripped_o   = state_reg == ST_TRIP;

  // checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_b_i);

  sequence trip_seen;
    trip_now;
  endsequence
  sequence gates_off;
    gate_hi_o == 3'h0 && gate_lo_o == 3'h0;
  endsequence

  stamp_capture_a: assert property (zc_hit |=> stamp_new_o && stamp_o == $past(timer_reg)) else $error("stamp missed");
  pair_overlap_a: assert property ((gate_hi_o & gate_lo_o & {3{!six_indep_i}}) == 3'h0) else $error("pair overlap");
  trip_off_a: assert property (trip_seen |=> gates_off [*2]) else $error("gates on after trip");
  two_phase_a: assert property (!six_indep_i && !$past(six_indep_i) |-> $countones(gate_hi_o | gate_lo_o) <= 2) else $error("more than two phases");
  zc_sched_a: assert property (zc_hit && !comm_hit && have_reg |=> due_reg == stamp_o + (period_o >> 1)) else $error("bad schedule");
  zc_first_a: assert property (zc_pend_reg |-> evt_o && evt_zc_o) else $error("crossing not first");
  timer_tick_a: assert property (tick |=> timer_reg == $past(timer_reg) + 1'b1) else $error("timer stalled");
  torque_up_a: assert property (state_reg == ST_RUN && !trip_now && run_i && torque_mode_i && cur_valid_i && cur_i < cur_ref_i && duty_reg < DUTY_MAX |=> duty_reg == $past(duty_reg) + 1'b1) else $error("duty not raised");
  torque_dn_a: assert property (state_reg == ST_RUN && torque_mode_i && cur_valid_i && cur_i > cur_ref_i && duty_reg != '0 |=> duty_reg == $past(duty_reg) - 1'b1) else $error("duty not lowered");
  start_track_a: assert property (state_reg == ST_IDLE ##1 state_reg == ST_RUN |-> period_reg == TMR_W'(START_STEP) && $stable(step_reg)) else $error("bad start");
  trip_hold_a: assert property (state_reg == ST_TRIP && !rearm_i |=> (state_reg == ST_TRIP) and gates_off) else $error("left trip");

endmodule

// [verif/bridge_model.sv]
// inverter bridge and motor stand-in for the commutation bench
// assumes gates are sampled on ref_clk_i; floating phase alternates
`timescale 1ns/10ps
module bridge_model (
  input  wire logic        ref_clk_i, // system clock
  input  wire logic [2:0]  hi_i,      // high-side gates
  input  wire logic [2:0]  lo_i,      // low-side gates
  output logic             smp_vld_o, // one-cycle sample strobe
  output logic [11:0]      smp_o,     // floating-phase sample
  output int               shoot_o    // shoot-through count
);
  logic [5:0] div_reg;                // sample spacing, 64 cycles
  initial
  begin
    div_reg   = 6'h00;
    smp_vld_o = 1'b0;
    smp_o     = 12'h000;
    shoot_o   = 0;
  end
  // strobes swing either side of the 12'h800 neutral, so every step
  // sees a crossing on its second sample; a shorted leg is counted
  always @(posedge ref_clk_i)
  begin
    div_reg   <= div_reg + 6'h01;
    smp_vld_o <= (div_reg == 6'h00);
    if (div_reg == 6'h00)
      smp_o <= smp_o ^ 12'hc00;
    if (|(hi_i & lo_i))
      shoot_o <= shoot_o + 1;
  end
endmodule

// [verif/test_sensorless_commutation.sv]
// self-checking bench for the sensorless commutation block
// assumes bridge_model feeds the floating-phase samples
`timescale 1ns/10ps
module test_sensorless_commutation;
  import bldc_pkg::*;
  logic        ref_clk_i = 1'b0, rst_b_i = 1'b0;     // clock, reset
  logic        run_i, torque_i, six_i, trip_b, oc_i; // controls
  logic        rearm_i, cur_vld, ack_i;              // pulses
  logic [12:0] duty_i;                               // duty, cycles
  logic        dir_i;                                // step order
  logic [5:0]  mask_i;                               // independent mask
  logic [11:0] cur_i;                                // sense level
  logic [2:0]  hi_o, lo_o, step_o;                   // gates, step
  logic [1:0]  fl_o;                                 // floating phase
  logic [15:0] stamp_o, period_o;                    // timer values
  logic        stamp_new, evt_o, zc_o, trip_o, svld; // flags
  logic [11:0] smp;                                  // sample value
  int          shoots, mismatches = 0, compares = 0; // tallies
  always #5 ref_clk_i = ~ref_clk_i;
  // short carrier and start step keep the run brief
  sensorless_commutation #(.PWM_PERIOD(50), .START_STEP(20)) i_dut (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .run_i(run_i),
    .dir_i(dir_i), .torque_mode_i(torque_i), .six_indep_i(six_i),
    .indep_mask_i(mask_i), .duty_i(duty_i), .dead_i(8'h04),
    .fault_trip_b_i(trip_b), .oc_cmp_i(oc_i), .rearm_i(rearm_i),
    .bemf_valid_i(svld), .bemf_i(smp), .bemf_mid_i(12'h800),
    .cur_valid_i(cur_vld), .cur_i(cur_i), .cur_ref_i(12'h600),
    .evt_ack_i(ack_i), .gate_hi_o(hi_o), .gate_lo_o(lo_o),
    .float_ph_o(fl_o), .step_o(step_o), .stamp_o(stamp_o),
    .stamp_new_o(stamp_new), .period_o(period_o), .evt_o(evt_o),
    .evt_zc_o(zc_o), .tripped_o(trip_o));
  bridge_model i_bridge (.ref_clk_i(ref_clk_i), .hi_i(hi_o),
    .lo_i(lo_o), .smp_vld_o(svld), .smp_o(smp), .shoot_o(shoots));
  task check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task finish_test;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // bounded wait, a miss shows up as a false flag in the next check
  task wait_zc;
    int n;
    n = 0;
    do @(negedge ref_clk_i); while (stamp_new !== 1'b1 && ++n < 6000);
  endtask
  // one-cycle pulse on ack (0), current strobe (1) or rearm (2)
  task pulse(input int sel);
    @(posedge ref_clk_i)
    begin
      ack_i   <= (sel == 0);
      cur_vld <= (sel == 1);
      rearm_i <= (sel == 2);
    end
    @(posedge ref_clk_i) {ack_i, cur_vld, rearm_i} <= 3'h0;
    @(negedge ref_clk_i);
  endtask
  // gates gathered over more than a carrier, so the pwm phase is moot
  task run_test;
    logic [2:0] seen_hi, seen_any;
    seen_hi  = 3'h0;
    seen_any = 3'h0;
    @(posedge ref_clk_i) run_i <= 1'b1;
    repeat (20) @(negedge ref_clk_i);                 // past dead time
    repeat (60)
    begin
      @(negedge ref_clk_i);
      seen_hi  = seen_hi | hi_o;
      seen_any = seen_any | hi_o | lo_o;
    end
    check(16'(seen_hi != 3'h0), 16'h0001);
    check(16'($countones(seen_any)), 16'h0002);
    check(16'(seen_any[fl_o]), 16'h0000);
  endtask
  // crossing stamp, then crossing shown ahead of a current event
  task zc_test;
    @(posedge ref_clk_i) torque_i <= 1'b1;
    wait_zc();
    check({stamp_new, evt_o, zc_o}, 16'h0007);
    check(16'(stamp_o != 16'h0000), 16'h0001);
    pulse(0);
    pulse(1);
    wait_zc();
    check({evt_o, zc_o}, 16'h0003);
    pulse(0);
    check({evt_o, zc_o}, 16'h0002);
    pulse(0);
    check(16'(evt_o), 16'h0000);
    @(posedge ref_clk_i) cur_i <= 12'h700;            // above target
    pulse(1);
    pulse(0);
  endtask
  // commutation steps down with dir_i set and up with it clear
  task dir_test(input logic dn);
    int was, n;
    @(posedge ref_clk_i) dir_i <= dn;
    @(negedge ref_clk_i);
    was = int'(step_o);
    n   = 0;
    while (int'(step_o) == was && n < 6000)
    begin
      @(negedge ref_clk_i);
      n++;
    end
    check(16'(step_o), 16'(dn ? (was + 5) % 6 : (was + 1) % 6));
  endtask
  // trip by pin or comparator, held until quiet and rearmed
  task trip_test(input logic by_oc);
    @(posedge ref_clk_i)
    begin
      oc_i   <= by_oc;
      trip_b <= by_oc;
    end
    repeat (6) @(negedge ref_clk_i);
    check({hi_o, lo_o, trip_o}, 16'h0001);
    pulse(2);
    check(16'(trip_o), 16'h0001);
    @(posedge ref_clk_i)
    begin
      oc_i   <= 1'b0;
      trip_b <= 1'b1;
    end
    repeat (8) @(negedge ref_clk_i);
    check({hi_o, lo_o, trip_o}, 16'h0001);
    pulse(2);
    repeat (2) @(negedge ref_clk_i);
    check(16'(trip_o), 16'h0000);
  endtask
  // six independent outputs follow the mask at the duty of duty_i
  task indep_test;
    logic [5:0] seen;
    int         on;
    seen = 6'h00;
    on   = 0;
    @(posedge ref_clk_i)
    begin
      six_i    <= 1'b1;
      torque_i <= 1'b0;
      mask_i   <= 6'h21;
      duty_i   <= 13'd25;
    end
    repeat (10) @(negedge ref_clk_i);
    repeat (50)
    begin
      @(negedge ref_clk_i);
      seen = seen | {hi_o, lo_o};
      on   = on + int'(hi_o[0]);
    end
    check(16'(seen), 16'h000c);
    check(16'(on), 16'h0019);
  endtask
  initial
  begin
    {run_i, torque_i, six_i, oc_i, rearm_i, cur_vld, ack_i, dir_i} = 8'h00;
    trip_b = 1'b1;
    duty_i = 13'd40;
    mask_i = 6'h00;
    cur_i  = 12'h400;
    repeat (5) @(posedge ref_clk_i);
    rst_b_i <= 1'b1;
    @(negedge ref_clk_i);
    check({hi_o, lo_o, fl_o, trip_o}, 16'h0004);
    run_test();
    zc_test();
    dir_test(1'b1);
    dir_test(1'b0);
    trip_test(1'b0);
    run_test();
    trip_test(1'b1);
    indep_test();
    check(16'(shoots), 16'h0000);
    finish_test();
  end
  // cut a hang short well past the expected run length
  initial
  begin
    #400000;
    mismatches++;
    finish_test();
  end
endmodule
